// ==== logic/psrm_top.sv ====
// Host bus target for the direct register window and its service request engine.
// Assumes a host bus clocked by core_clk; shared signals are split into in, out and enable.
`timescale 1ns/1ps
`default_nettype none
module psrm_top #(
    parameter int unsigned INIT_CYCLES = 64
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic idsel,
    input wire logic [3:0] cbe_n,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    output logic par_out,
    output logic par_oe,
    output logic devsel_n_out,
    output logic trdy_n_out,
    output logic stop_n_out,
    output logic target_ctl_oe,
    input wire logic master_active,
    input wire logic [31:0] rx_port_alive_in,
    input wire logic [31:0] tx_port_alive_in,
    output logic soft_reset_pulse,
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    input wire logic fetch_ack,
    input wire logic [21:0] fetch_desc_addr,
    input wire logic [31:0] fetch_desc_data,
    output logic ind_wr,
    output logic [21:0] ind_addr,
    output logic [31:0] ind_data,
    output logic [31:0] irq_queue_base,
    output logic [31:0] irq_queue_size
);
    typedef struct packed {
        psrm_pkg::psrm_tgt_state_t state;
        logic [19:0] offset;
        logic is_cfg;
        logic is_write;
        logic [11:0] bar;
        logic [31:0] rx_alive;
        logic [31:0] tx_alive;
        logic [31:0] irq_summary_word;
        logic [31:0] irq_queue_base;
        logic [31:0] irq_queue_size;
        logic [31:0] request_list_base;
        logic [15:0] init_cnt;
        logic init_done;
        logic [31:0] rd_data;
        logic ad_oe;
        logic par;
        logic soft_pulse;
        logic start;
        logic [9:0] start_count;
    } psrm_state_t;

    psrm_state_t s_reg;
    psrm_state_t s_next;

    logic [9:0] eng_pending;
    logic eng_busy;
    logic eng_rst_n;
    logic addr_phase;
    logic mem_hit;
    logic cfg_hit;
    logic data_done;
    logic [31:0] rd_mux;
    logic [9:0] count_view;
    logic [31:0] bar_merged;
    logic [31:0] count_merged;

    // Merge a write into a word honouring the active-low byte enables
    function automatic logic [31:0] psrm_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] be_n);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (!be_n[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Soft reset restarts the engine as well as the register set
    assign eng_rst_n = rst_n & ~s_reg.soft_pulse;

    psrm_srq_engine u_engine (
        .core_clk(core_clk),
        .rst_n(eng_rst_n),
        .start(s_reg.start),
        .start_count(s_reg.start_count),
        .list_base(s_reg.request_list_base),
        .pending_request_count(eng_pending),
        .busy(eng_busy),
        .fetch_req(fetch_req),
        .fetch_addr(fetch_addr),
        .fetch_ack(fetch_ack),
        .fetch_desc_addr(fetch_desc_addr),
        .fetch_desc_data(fetch_desc_data),
        .ind_wr(ind_wr),
        .ind_addr(ind_addr),
        .ind_data(ind_data)
    );

    // The address phase is the first cycle of frame while the target is idle
    assign addr_phase = !frame_n && (s_reg.state == psrm_pkg::PSRM_T_IDLE);

    // Own master cycles must never be reflected back as target hits
    assign mem_hit = !master_active
        && (cbe_n == psrm_pkg::CMD_MEM_READ || cbe_n == psrm_pkg::CMD_MEM_WRITE)
        && (ad_in[31:psrm_pkg::OFFSET_BITS] == s_reg.bar);

    assign cfg_hit = !master_active && idsel && (ad_in[1:0] == 2'b00)
        && (cbe_n == psrm_pkg::CMD_CFG_READ || cbe_n == psrm_pkg::CMD_CFG_WRITE);

    assign data_done = (s_reg.state == psrm_pkg::PSRM_T_DATA) && !irdy_n;

    // Count shows all ones until the start-up delay has run out
    assign count_view = s_reg.init_done ? eng_pending : psrm_pkg::COUNT_ALL_ONES;

    // Byte-lane merges for the two fields narrower than a bus word
    assign bar_merged = psrm_merge({s_reg.bar, {psrm_pkg::OFFSET_BITS{1'b0}}}, ad_in, cbe_n);
    assign count_merged = psrm_merge({22'h000000, eng_pending}, ad_in, cbe_n);

    always_comb begin
        rd_mux = psrm_pkg::REG_RESET;
        // Decoded from the latched address so the read mux never loops through s_next
        if (s_reg.is_cfg) begin
            if (s_reg.offset[7:0] == psrm_pkg::CFG_BAR_OFFSET) begin
                rd_mux = {s_reg.bar, {psrm_pkg::OFFSET_BITS{1'b0}}};
            end
        end else begin
            case (s_reg.offset)
                psrm_pkg::OFF_RX_ALIVE: rd_mux = s_reg.rx_alive;
                psrm_pkg::OFF_TX_ALIVE: rd_mux = s_reg.tx_alive;
                psrm_pkg::OFF_IRQ_SUMMARY: rd_mux = s_reg.irq_summary_word;
                psrm_pkg::OFF_IRQ_BASE: rd_mux = s_reg.irq_queue_base;
                psrm_pkg::OFF_IRQ_SIZE: rd_mux = s_reg.irq_queue_size;
                psrm_pkg::OFF_LIST_COUNT: rd_mux = {22'h000000, count_view};
                psrm_pkg::OFF_LIST_BASE: rd_mux = s_reg.request_list_base;
                default: rd_mux = psrm_pkg::REG_RESET;
            endcase
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.soft_pulse = 1'b0;
        s_next.start = 1'b0;
        // Port-alive bits follow the serial ports; the host can only look
        s_next.rx_alive = rx_port_alive_in;
        s_next.tx_alive = tx_port_alive_in;
        if (!s_reg.init_done) begin
            if (s_reg.init_cnt == 16'(INIT_CYCLES - 1)) begin
                s_next.init_done = 1'b1;
            end else begin
                s_next.init_cnt = s_reg.init_cnt + 16'h0001;
            end
        end
        case (s_reg.state)
            psrm_pkg::PSRM_T_IDLE: begin
                if (addr_phase && (mem_hit || cfg_hit)) begin
                    s_next.offset = cfg_hit ? {12'h000, ad_in[7:0]}
                                            : ad_in[psrm_pkg::OFFSET_BITS-1:0];
                    s_next.is_cfg = cfg_hit;
                    s_next.is_write = (cbe_n == psrm_pkg::CMD_MEM_WRITE)
                        || (cbe_n == psrm_pkg::CMD_CFG_WRITE);
                    s_next.ad_oe = !s_next.is_write;
                    s_next.state = psrm_pkg::PSRM_T_CLAIM;
                end
            end
            psrm_pkg::PSRM_T_CLAIM: begin
                s_next.rd_data = rd_mux;
                s_next.state = psrm_pkg::PSRM_T_DATA;
            end
            psrm_pkg::PSRM_T_DATA: begin
                // One data phase per access: stop rides with trdy, so bursts disconnect
                if (data_done) begin
                    s_next.par = ^{s_reg.rd_data, cbe_n};
                    // AD is let go at once; parity (reads only) and the target controls are driven in the turn cycle
                    s_next.ad_oe = 1'b0;
                    s_next.state = psrm_pkg::PSRM_T_TURN;
                    if (s_reg.is_write && s_reg.is_cfg) begin
                        if (s_reg.offset[7:0] == psrm_pkg::CFG_BAR_OFFSET) begin
                            s_next.bar = bar_merged[31:psrm_pkg::OFFSET_BITS];
                        end
                    end else if (s_reg.is_write) begin
                        case (s_reg.offset)
                            psrm_pkg::OFF_IRQ_SUMMARY: begin
                                s_next.irq_summary_word =
                                    psrm_merge(s_reg.irq_summary_word, ad_in, cbe_n);
                            end
                            psrm_pkg::OFF_IRQ_BASE: begin
                                s_next.irq_queue_base =
                                    psrm_merge(s_reg.irq_queue_base, ad_in, cbe_n);
                            end
                            psrm_pkg::OFF_IRQ_SIZE: begin
                                s_next.irq_queue_size =
                                    psrm_merge(s_reg.irq_queue_size, ad_in, cbe_n);
                            end
                            psrm_pkg::OFF_LIST_COUNT: begin
                                // Rewriting mid-list is the host's fault; it restarts nothing
                                if (s_reg.init_done && !eng_busy) begin
                                    s_next.start_count = count_merged[9:0];
                                    s_next.start = 1'b1;
                                end
                            end
                            psrm_pkg::OFF_LIST_BASE: begin
                                s_next.request_list_base =
                                    psrm_merge(s_reg.request_list_base, ad_in, cbe_n);
                            end
                            psrm_pkg::OFF_SOFT_RESET: begin
                                s_next.soft_pulse = 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            psrm_pkg::PSRM_T_TURN: begin
                s_next.ad_oe = 1'b0;
                s_next.state = psrm_pkg::PSRM_T_IDLE;
            end
            default: s_next.state = psrm_pkg::PSRM_T_IDLE;
        endcase
        // Soft reset clears the chip but keeps the window so the host can reach it again
        if (s_reg.soft_pulse) begin
            s_next.irq_summary_word = psrm_pkg::REG_RESET;
            s_next.irq_queue_base = psrm_pkg::REG_RESET;
            s_next.irq_queue_size = psrm_pkg::REG_RESET;
            s_next.request_list_base = psrm_pkg::REG_RESET;
            s_next.init_cnt = 16'h0000;
            s_next.init_done = 1'b0;
            s_next.start = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ad_out = s_reg.rd_data;
    assign ad_oe = s_reg.ad_oe;
    assign par_out = s_reg.par;
    assign par_oe = (s_reg.state == psrm_pkg::PSRM_T_TURN) && !s_reg.is_write;
    assign devsel_n_out = !(s_reg.state == psrm_pkg::PSRM_T_CLAIM
        || s_reg.state == psrm_pkg::PSRM_T_DATA);
    assign trdy_n_out = !(s_reg.state == psrm_pkg::PSRM_T_DATA);
    assign stop_n_out = !(s_reg.state == psrm_pkg::PSRM_T_DATA);
    // Controls are driven high for one turn cycle before release
    assign target_ctl_oe = (s_reg.state != psrm_pkg::PSRM_T_IDLE);
    assign soft_reset_pulse = s_reg.soft_pulse;
    assign irq_queue_base = s_reg.irq_queue_base;
    assign irq_queue_size = s_reg.irq_queue_size;
endmodule // psrm_top
`default_nettype wire

// ==== logic/psrm_pkg.sv ====
// Constants and types shared by the register front end and its request engine.
// Assumes one clock domain, the host bus clock, with a synchronous active-low reset.
`default_nettype none
package psrm_pkg;
    localparam int unsigned WINDOW_BYTES = 32'h0010_0000;
    localparam int unsigned BASE_BITS = 12;
    localparam int unsigned OFFSET_BITS = 20;
    localparam int unsigned IND_ADDR_BITS = 22;
    localparam int unsigned COUNT_BITS = 10;
    localparam int unsigned PORTS = 32;

    localparam logic [5:0] CFG_BAR_INDEX = 6'h04;
    localparam logic [7:0] CFG_BAR_OFFSET = 8'h10;

    localparam logic [19:0] OFF_RX_ALIVE = 20'h00000;
    localparam logic [19:0] OFF_TX_ALIVE = 20'h00004;
    localparam logic [19:0] OFF_IRQ_SUMMARY = 20'h00008;
    localparam logic [19:0] OFF_IRQ_BASE = 20'h0000C;
    localparam logic [19:0] OFF_IRQ_SIZE = 20'h00010;
    localparam logic [19:0] OFF_LIST_COUNT = 20'h00014;
    localparam logic [19:0] OFF_LIST_BASE = 20'h00018;
    localparam logic [19:0] OFF_SOFT_RESET = 20'h00020;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [9:0] COUNT_ALL_ONES = 10'h3FF;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;

    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_CFG_READ = 4'hA;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hB;

    typedef enum logic [1:0] {
        PSRM_T_IDLE = 2'b00,
        PSRM_T_CLAIM = 2'b01,
        PSRM_T_DATA = 2'b10,
        PSRM_T_TURN = 2'b11
    } psrm_tgt_state_t;

    typedef enum logic [1:0] {
        PSRM_E_IDLE = 2'b00,
        PSRM_E_FETCH = 2'b01,
        PSRM_E_WRITE = 2'b10
    } psrm_eng_state_t;
endpackage
`default_nettype wire

// ==== logic/psrm_srq_engine.sv ====
// Service request engine: walks the descriptor table in shared memory.
// Assumes a fetch agent that returns one descriptor per request and holds its ack one cycle.
`timescale 1ns/1ps
`default_nettype none
module psrm_srq_engine (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [9:0] start_count,
    input wire logic [31:0] list_base,
    output logic [9:0] pending_request_count,
    output logic busy,
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    input wire logic fetch_ack,
    input wire logic [21:0] fetch_desc_addr,
    input wire logic [31:0] fetch_desc_data,
    output logic ind_wr,
    output logic [21:0] ind_addr,
    output logic [31:0] ind_data
);
    typedef struct packed {
        psrm_pkg::psrm_eng_state_t state;
        logic [9:0] remaining;
        logic [31:0] ptr;
        logic wr;
        logic [21:0] addr;
        logic [31:0] data;
    } psrm_eng_t;

    psrm_eng_t s_reg;
    psrm_eng_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.wr = 1'b0;
        case (s_reg.state)
            psrm_pkg::PSRM_E_IDLE: begin
                if (start && start_count != '0) begin
                    s_next.remaining = start_count;
                    s_next.ptr = list_base;
                    s_next.state = psrm_pkg::PSRM_E_FETCH;
                end
            end
            psrm_pkg::PSRM_E_FETCH: begin
                if (fetch_ack) begin
                    s_next.addr = fetch_desc_addr;
                    s_next.data = fetch_desc_data;
                    s_next.state = psrm_pkg::PSRM_E_WRITE;
                end
            end
            psrm_pkg::PSRM_E_WRITE: begin
                s_next.wr = 1'b1;
                s_next.remaining = s_reg.remaining - 10'h001;
                s_next.ptr = s_reg.ptr + psrm_pkg::DESC_STRIDE;
                s_next.state = (s_reg.remaining == 10'h001) ? psrm_pkg::PSRM_E_IDLE
                                                            : psrm_pkg::PSRM_E_FETCH;
            end
            default: s_next.state = psrm_pkg::PSRM_E_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pending_request_count = s_reg.remaining;
    assign busy = (s_reg.state != psrm_pkg::PSRM_E_IDLE);
    assign fetch_req = (s_reg.state == psrm_pkg::PSRM_E_FETCH);
    assign fetch_addr = s_reg.ptr;
    assign ind_wr = s_reg.wr;
    assign ind_addr = s_reg.addr;
    assign ind_data = s_reg.data;
endmodule // psrm_srq_engine
`default_nettype wire

// ==== tb/psrm_top_props.sv ====
// Port checker for the host bus target and its request engine.
// Bound to psrm_top; sees only that module's ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module psrm_top_props #(
    parameter int unsigned INIT_CYCLES = 64
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic [3:0] cbe_n,
    input wire logic master_active,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe,
    input wire logic par_out,
    input wire logic par_oe,
    input wire logic devsel_n_out,
    input wire logic trdy_n_out,
    input wire logic stop_n_out,
    input wire logic target_ctl_oe,
    input wire logic soft_reset_pulse,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_ack,
    input wire logic [21:0] fetch_desc_addr,
    input wire logic ind_wr,
    input wire logic [21:0] ind_addr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Data edge of the last cycle, kept as a flop so the pulse check stays simple
    logic done_reg;
    always_ff @(posedge core_clk) begin
        done_reg <= rst_n && !trdy_n_out && !irdy_n;
    end
    self_claim_a: assert property (master_active && $fell(frame_n) |=> devsel_n_out)
        else $error("own master cycle was claimed");
    foreign_cmd_a: assert property ($fell(frame_n) && !(cbe_n inside {4'h6, 4'h7, 4'hA, 4'hB})
        |=> devsel_n_out) else $error("unsupported command was claimed");
    claim_order_a: assert property ($fell(devsel_n_out) |-> target_ctl_oe
        ##1 (!trdy_n_out && !stop_n_out && !devsel_n_out)) else $error("claim sequence wrong");
    turn_release_a: assert property ((!trdy_n_out && !irdy_n) |=>
        (devsel_n_out && trdy_n_out && stop_n_out && target_ctl_oe) ##1 !target_ctl_oe)
        else $error("turnaround wrong");
    read_turn_a: assert property ((ad_oe && !trdy_n_out && !irdy_n) |=> (!ad_oe && par_oe))
        else $error("read turnaround wrong");
    read_parity_a: assert property (par_oe |-> par_out == ^{$past(ad_out), $past(cbe_n)})
        else $error("read parity wrong");
    soft_pulse_a: assert property (soft_reset_pulse |-> done_reg ##1 !soft_reset_pulse)
        else $error("soft reset pulse wrong");
    ind_pulse_a: assert property (ind_wr |-> $past(fetch_ack, 2) ##1 !ind_wr)
        else $error("indirect write pulse wrong");
    ind_addr_a: assert property (ind_wr |-> ind_addr == $past(fetch_desc_addr, 2))
        else $error("indirect address wrong");
    fetch_step_a: assert property (ind_wr |-> fetch_addr == $past(fetch_addr) + 32'h8)
        else $error("descriptor stride wrong");
    cover property (ad_oe && !trdy_n_out && !irdy_n);
    cover property (ind_wr);
    cover property (soft_reset_pulse);
endmodule // psrm_top_props
bind psrm_top psrm_top_props #(.INIT_CYCLES(INIT_CYCLES)) psrm_top_props_inst (
    .core_clk, .rst_n, .frame_n, .irdy_n, .cbe_n, .master_active, .ad_out, .ad_oe, .par_out,
    .par_oe, .devsel_n_out, .trdy_n_out, .stop_n_out, .target_ctl_oe, .soft_reset_pulse,
    .fetch_addr, .fetch_ack, .fetch_desc_addr, .ind_wr, .ind_addr
);
`default_nettype wire

// ==== tb/psrm_mem_model.sv ====
// Shared-memory model that answers descriptor fetches.
// Assumes the engine holds fetch_req until it sees a one-cycle fetch_ack.
`timescale 1ns/1ps
`default_nettype none
module psrm_mem_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_ack,
    output logic [21:0] fetch_desc_addr,
    output logic [31:0] fetch_desc_data
);
    logic [4:0] wait_reg;
    // Image is fixed before any start: descriptor derived from its own address
    always_ff @(posedge core_clk) begin
        if (!rst_n || !fetch_req || fetch_ack) begin
            wait_reg <= 5'h0;
            fetch_ack <= 1'b0;
        end else begin
            wait_reg <= wait_reg + 5'h1;
            fetch_ack <= (wait_reg == (slow ? 5'hC : 5'h1));
        end
    end
    // Outside the ack cycle the lines wander so stale values cannot pass
    assign fetch_desc_addr = fetch_ack ? fetch_addr[23:2] : {17'h1FFFF, ~wait_reg};
    assign fetch_desc_data = fetch_ack ? ~fetch_addr : {27'h0, wait_reg};
endmodule // psrm_mem_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the direct register window and request engine.
// Assumes psrm_mem_model as shared memory and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module testbench;
    // Window kept clear of the shared-memory range the descriptor list lives in
    localparam logic [31:0] BASE = 32'h5A30_0000;
    localparam logic [31:0] LIST = 32'h00FF_FFF0;
    typedef struct packed {
        logic [19:0] off;
        logic [31:0] wd;
        logic [3:0] be_n;
        logic [31:0] ex;
    } psrm_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic frame_n = 1'b1;
    logic irdy_n = 1'b1;
    logic idsel = 1'b0;
    logic [3:0] cbe_n = 4'hF;
    logic [31:0] ad_in = 32'h0;
    logic master_active = 1'b0;
    logic [31:0] rx_port_alive_in = 32'h0;
    logic [31:0] tx_port_alive_in = 32'h0;
    logic slow = 1'b1;
    logic [31:0] ad_out, fetch_addr, fetch_desc_data, ind_data, irq_queue_base, irq_queue_size;
    logic [21:0] fetch_desc_addr, ind_addr;
    logic ad_oe, par_out, par_oe, devsel_n_out, trdy_n_out, stop_n_out, target_ctl_oe;
    logic soft_reset_pulse, fetch_req, fetch_ack, ind_wr, hit;
    logic [31:0] rd, exp_a;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_ind = 0;
    int first = 0;
    int n_soft = 0;
    psrm_row_t rows [8] = '{
        '{20'h00000, 32'hFFFF_FFFF, 4'h0, 32'hA5C3_0F0F},
        '{20'h00004, 32'hFFFF_FFFF, 4'h0, 32'h0000_1234},
        '{20'h00008, 32'h1234_5678, 4'h0, 32'h1234_5678},
        '{20'h0000C, 32'h89AB_CDEF, 4'h0, 32'h89AB_CDEF},
        '{20'h00010, 32'hDEAD_BEEF, 4'hC, 32'h0000_BEEF},
        '{20'h00018, LIST, 4'h0, LIST},
        '{20'h0001C, 32'hFFFF_FFFF, 4'h0, 32'h0},
        '{20'h00024, 32'hFFFF_FFFF, 4'h0, 32'h0}};
    logic [35:0] refuse [3] = '{{4'h7, 32'h5A40_0008}, {4'h7, BASE | 32'h8}, {4'h3, BASE | 32'h8}};
    psrm_top #(.INIT_CYCLES(40)) psrm_top_inst (
        .core_clk, .rst_n, .frame_n, .irdy_n, .idsel, .cbe_n, .ad_in, .ad_out, .ad_oe, .par_out,
        .par_oe, .devsel_n_out, .trdy_n_out, .stop_n_out, .target_ctl_oe, .master_active,
        .rx_port_alive_in, .tx_port_alive_in, .soft_reset_pulse, .fetch_req, .fetch_addr,
        .fetch_ack, .fetch_desc_addr, .fetch_desc_data, .ind_wr, .ind_addr, .ind_data,
        .irq_queue_base, .irq_queue_size
    );
    psrm_mem_model psrm_mem_model_inst (
        .core_clk, .rst_n, .slow, .fetch_req, .fetch_addr, .fetch_ack, .fetch_desc_addr,
        .fetch_desc_data
    );
    assign exp_a = LIST + 32'((n_ind - first) * 8);
    always #10 core_clk = ~core_clk;
    task automatic end_sim();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One data phase per frame; irdy held until trdy is seen, a miss gives up after 6
    task automatic bus(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd,
                       input logic [3:0] be_n, input logic sel);
        int n = 0;
        @(negedge core_clk);
        frame_n = 1'b0;
        cbe_n = cmd;
        ad_in = addr;
        idsel = sel;
        @(negedge core_clk);
        frame_n = 1'b1;
        irdy_n = 1'b0;
        cbe_n = be_n;
        ad_in = wd;
        idsel = 1'b0;
        @(negedge core_clk);
        while (trdy_n_out !== 1'b0 && n < 6) begin
            @(negedge core_clk);
            n++;
        end
        hit = (trdy_n_out === 1'b0);
        rd = ad_out;
        @(negedge core_clk);
        irdy_n = 1'b1;
        cbe_n = 4'hF;
        ad_in = ~wd;
    endtask
    task automatic rdr(input logic [19:0] off);
        bus(psrm_pkg::CMD_MEM_READ, BASE | {12'h0, off}, 32'h0, 4'h0, 1'b0);
    endtask
    task automatic wrr(input logic [19:0] off, input logic [31:0] wd, input logic [3:0] be_n);
        bus(psrm_pkg::CMD_MEM_WRITE, BASE | {12'h0, off}, wd, be_n, 1'b0);
    endtask
    // Host may only start a list once the pending count reads zero
    task automatic wait_zero();
        int n = 0;
        rdr(20'h14);
        while (rd !== 32'h0 && n < 30) begin
            rdr(20'h14);
            n++;
        end
        `CHECK("count zero", 32'h0, rd)
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (soft_reset_pulse === 1'b1) n_soft++;
        if (ind_wr === 1'b1) begin
            `CHECK("ind addr", exp_a[23:2], ind_addr)
            `CHECK("ind data", ~exp_a, ind_data)
            n_ind++;
        end
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        bus(psrm_pkg::CMD_CFG_READ, 32'h10, 32'h0, 4'h0, 1'b1);
        `CHECK("bar reset", 32'h0, rd)
        bus(psrm_pkg::CMD_CFG_WRITE, 32'h10, 32'hFFFF_FFFF, 4'h0, 1'b1);
        bus(psrm_pkg::CMD_CFG_READ, 32'h10, 32'h0, 4'h0, 1'b1);
        `CHECK("bar size", 32'hFFF0_0000, rd)
        bus(psrm_pkg::CMD_CFG_WRITE, 32'h10, BASE, 4'h0, 1'b1);
        rdr(20'h14);
        `CHECK("count init", 32'h0000_03FF, rd)
        for (int i = 0; i < 6; i++) begin
            rdr(rows[i].off);
            `CHECK("reset value", 32'h0, rd)
        end
        rx_port_alive_in = 32'hA5C3_0F0F;
        tx_port_alive_in = 32'h0000_1234;
        wait_zero();
        foreach (rows[i]) begin
            wrr(rows[i].off, rows[i].wd, rows[i].be_n);
            rdr(rows[i].off);
            `CHECK("row read", rows[i].ex, rd)
        end
        `CHECK("queue base out", 32'h89AB_CDEF, irq_queue_base)
        `CHECK("queue size out", 32'h0000_BEEF, irq_queue_size)
        foreach (refuse[i]) begin
            master_active = (i == 1);
            bus(refuse[i][35:32], refuse[i][31:0], 32'h0, 4'h0, 1'b0);
            `CHECK("refused", 1'b0, hit)
        end
        master_active = 1'b0;
        rdr(20'h08);
        `CHECK("untouched", 32'h1234_5678, rd)
        wrr(20'h14, 32'h3, 4'h0);
        rdr(20'h14);
        `CHECK("count running", 32'h3, rd)
        wait_zero();
        `CHECK("first list", 3, n_ind)
        slow = 1'b0;
        first = n_ind;
        wrr(20'h14, 32'h2, 4'h0);
        wait_zero();
        `CHECK("second list", 5, n_ind)
        wrr(20'h20, 32'h1, 4'h0);
        rdr(20'h08);
        `CHECK("soft cleared", 32'h0, rd)
        rdr(20'h14);
        `CHECK("soft init", 32'h0000_03FF, rd)
        `CHECK("soft pulses", 1, n_soft)
        end_sim();
    end
endmodule // testbench
`default_nettype wire
